// ==== two_wire_serial_shift_unit_tb.sv ====
/*
  Self-checking bench for the two-wire serial shift unit core.
  Assumes usu_bus_master as the far side and pull-ups on both wires.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, x) \
  begin \
    check_count++; \
    if ((g) !== (x)) begin \
      error_cnt++; \
      $display("Error %0t: got %h expected %h", $time, (g), (x)); \
    end \
  end

module two_wire_serial_shift_unit_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] wire_mode, clock_source_sel;
  logic soft_clock_strobe, timer_match, data_wr, count_wr;
  logic sda_pin_output_latch, scl_pin_output_latch;
  logic sda_pin_direction, scl_pin_direction;
  logic [7:0] data_wdata, shift_data_register;
  logic [3:0] count_wdata, count;
  logic start_flag_clr, ovf_flag_clr, start_irq_en, ovf_irq_en;
  logic sda_out, sda_oe_n, scl_out, scl_oe_n;
  logic start_seen_flag, count_overflow_flag, start_irq, ovf_irq;
  logic m_scl_low, m_sda_low, s, ok, src;
  logic [3:0] p;
  logic [4:0] e;
  logic [7:0] addr, dat, rd;
  int error_cnt = 0;
  int check_count = 0;
  int seed, i, k;
  wire logic sda_w;
  wire logic scl_w;

  // Open-drain wires: any party pulling wins, else pull-up
  assign sda_w = !(m_sda_low || (!sda_oe_n && !sda_out));
  assign scl_w = !(m_scl_low || (!scl_oe_n && !scl_out));

  always #50 sys_clk = ~sys_clk;

  usu_core usu_core_i (
    .sys_clk, .rst, .sda_in(sda_w), .scl_in(scl_w), .sda_out, .sda_oe_n,
    .scl_out, .scl_oe_n, .wire_mode, .clock_source_sel, .soft_clock_strobe,
    .timer_match, .sda_pin_output_latch, .scl_pin_output_latch,
    .sda_pin_direction, .scl_pin_direction, .data_wr, .data_wdata, .count_wr,
    .count_wdata, .start_flag_clr, .ovf_flag_clr, .start_irq_en, .ovf_irq_en,
    .shift_data_register, .count, .start_seen_flag, .count_overflow_flag,
    .start_irq, .ovf_irq
  );

  usu_bus_master master_i (
    .sys_clk, .scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low)
  );

  task automatic end_sim;
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Software write of data, counter and SDA direction, then overflow clear.
  // SDA must settle two edges before the hold lets SCL rise, else the
  // detector sees SDA fall with SCL high and reports a false start.
  task automatic sw(input logic [7:0] d, input logic [3:0] c, input logic dir);
    @(negedge sys_clk);
    data_wr = 1'b1;
    data_wdata = d;
    count_wr = 1'b1;
    count_wdata = c;
    sda_pin_direction = dir;
    @(negedge sys_clk);
    data_wr = 1'b0;
    count_wr = 1'b0;
    @(negedge sys_clk);
    ovf_flag_clr = 1'b1;
    @(negedge sys_clk);
    ovf_flag_clr = 1'b0;
  endtask

  // One master bit; a stuck SCL ends the run
  task automatic mbit(input logic b);
    logic okb;
    master_i.bit_cycle(b, s, okb);
    if (okb !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
  endtask

  // Counter after k edges from preset p, wrap in the top bit
  function automatic logic [4:0] exp_cnt(input logic [3:0] pv, input int kv);
    return {1'b0, pv} + 5'(kv);
  endfunction

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    seed = 85821;
    {wire_mode, clock_source_sel, soft_clock_strobe, timer_match} = '0;
    {data_wr, count_wr, start_flag_clr, ovf_flag_clr} = '0;
    {start_irq_en, sda_pin_direction, scl_pin_direction} = '0;
    {sda_pin_output_latch, scl_pin_output_latch, ovf_irq_en} = 3'h7;
    data_wdata = 8'h00;
    count_wdata = 4'h0;
    repeat (4) @(posedge sys_clk);
    cyc(1);
    rst = 1'b0;
    cyc(2);
    `CHK({count, shift_data_register}, 12'h0FF)
    `CHK({start_seen_flag, count_overflow_flag, sda_oe_n, scl_oe_n}, 4'h3)
    // Strobe counting, first pass is the preset-F overflow interrupt
    for (i = 0; i < 12; i++) begin
      p = 4'($random(seed));
      k = ($random(seed) & 15) + 1;
      src = 1'($random(seed));
      if (i == 0) begin
        p = usu_pkg::COUNT_MAX;
        k = 1;
      end
      clock_source_sel = src ? usu_pkg::CS_TIMER_MATCH : usu_pkg::CS_SOFT_STROBE;
      sw(usu_pkg::DATA_RST, p, 1'b0);
      repeat (k) begin
        timer_match = src;
        soft_clock_strobe = !src;
        @(negedge sys_clk);
      end
      {timer_match, soft_clock_strobe} = 2'h0;
      cyc(3);
      e = exp_cnt(p, k);
      `CHK(count, e[3:0])
      `CHK(count_overflow_flag, e[4])
      `CHK(ovf_irq, e[4])
    end
    // External clock: one SCL edge overflows a preset of F
    wire_mode = usu_pkg::MODE_TWO;
    clock_source_sel = usu_pkg::CS_EXT_FALL;
    scl_pin_direction = 1'b1;
    sw(usu_pkg::DATA_RST, usu_pkg::COUNT_MAX, 1'b0);
    mbit(1'b1);
    cyc(4);
    `CHK(count, usu_pkg::COUNT_RST)
    `CHK(count_overflow_flag, 1'b1)
    master_i.stop_cond(ok);
    `CHK(ok, 1'b1)
    // Slave frame: start, address, ack, data byte, nack
    wire_mode = usu_pkg::MODE_TWO_OVF_HOLD;
    clock_source_sel = usu_pkg::CS_EXT_RISE;
    start_irq_en = 1'b1;
    sw(usu_pkg::DATA_RST, usu_pkg::COUNT_RST, 1'b0);
    master_i.start_cond();
    cyc(6);
    `CHK({start_seen_flag, start_irq}, 2'h3)
    `CHK(scl_oe_n, 1'b0)
    addr = 8'($random(seed));
    fork
      begin
        for (i = 7; i >= 0; i--) mbit(addr[i]);
      end
      begin
        cyc(10);
        `CHK(scl_w, 1'b0)
        start_flag_clr = 1'b1;
        count_wr = 1'b1;
        count_wdata = usu_pkg::COUNT_RST;
        cyc(1);
        start_flag_clr = 1'b0;
        count_wr = 1'b0;
      end
    join
    cyc(6);
    `CHK(shift_data_register, addr)
    `CHK({count_overflow_flag, start_seen_flag, scl_oe_n}, 3'h4)
    // Ack: slave pulls SDA through the data top bit
    fork
      mbit(1'b1);
      begin
        cyc(8);
        sw(8'h00, usu_pkg::COUNT_ACK_PRESET, 1'b1);
      end
    join
    `CHK(s, 1'b0)
    cyc(6);
    `CHK({count_overflow_flag, scl_oe_n}, 2'h2)
    dat = 8'($random(seed));
    fork
      begin
        for (i = 7; i >= 0; i--) mbit(dat[i]);
      end
      begin
        cyc(8);
        sw(usu_pkg::DATA_RST, usu_pkg::COUNT_RST, 1'b0);
      end
    join
    cyc(6);
    `CHK(shift_data_register, dat)
    // Nack: top bit one leaves SDA released
    fork
      mbit(1'b1);
      begin
        cyc(8);
        sw(usu_pkg::DATA_RST, usu_pkg::COUNT_ACK_PRESET, 1'b1);
      end
    join
    `CHK({s, sda_oe_n}, 2'h3)
    cyc(6);
    sw(usu_pkg::DATA_RST, usu_pkg::COUNT_RST, 1'b0);
    cyc(4);
    `CHK(scl_oe_n, 1'b1)
    master_i.stop_cond(ok);
    `CHK({ok, scl_w, sda_w}, 3'h7)
    // Read frame: direction bit one, slave sends a byte, master nacks it
    master_i.start_cond();
    cyc(6);
    addr = {7'($random(seed)), 1'b1};
    dat = 8'($random(seed));
    fork
      begin
        for (i = 7; i >= 0; i--) mbit(addr[i]);
      end
      begin
        cyc(10);
        start_flag_clr = 1'b1;
        count_wr = 1'b1;
        count_wdata = usu_pkg::COUNT_RST;
        cyc(1);
        start_flag_clr = 1'b0;
        count_wr = 1'b0;
      end
    join
    cyc(6);
    `CHK(shift_data_register, addr)
    fork
      mbit(1'b1);
      begin
        cyc(8);
        sw(8'h00, usu_pkg::COUNT_ACK_PRESET, 1'b1);
      end
    join
    cyc(6);
    fork
      begin
        for (i = 7; i >= 0; i--) begin
          mbit(1'b1);
          rd[i] = s;
        end
      end
      begin
        cyc(8);
        sw(dat, usu_pkg::COUNT_RST, 1'b1);
      end
    join
    `CHK(rd, dat)
    // Master ends the read by leaving its acknowledge bit released
    fork
      mbit(1'b1);
      begin
        cyc(8);
        sw(8'h00, usu_pkg::COUNT_ACK_PRESET, 1'b0);
      end
    join
    cyc(6);
    `CHK({shift_data_register, count_overflow_flag, scl_oe_n}, 10'h006)
    sw(usu_pkg::DATA_RST, usu_pkg::COUNT_RST, 1'b0);
    master_i.stop_cond(ok);
    `CHK(ok, 1'b1)
    // Port latch bit zero pulls SCL, the way a master clocks by hand
    scl_pin_output_latch = 1'b0;
    cyc(4);
    `CHK(scl_oe_n, 1'b0)
    // Port latch bit zero pulls SDA with the driver on
    sda_pin_direction = 1'b1;
    sda_pin_output_latch = 1'b0;
    cyc(4);
    `CHK(sda_oe_n, 1'b0)
    `CHK({sda_out, scl_out}, 2'h0)
    // Three-wire mode: no SDA drive, start hold gone, latch still rules SCL
    wire_mode = usu_pkg::MODE_THREE;
    cyc(4);
    `CHK({sda_oe_n, scl_oe_n, sda_out, scl_out}, 4'h8)
    end_sim();
  end
endmodule

`default_nettype wire

// ==== usu_bus_master.sv ====
/*
  Behavioural two-wire bus master that faces the shift unit in the bench.
  Assumes pull-ups on both wires; it only ever pulls a wire low.
*/
`timescale 1ns/1ps
`default_nettype none

module usu_bus_master (
  input wire logic sys_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  // Half of the 800 ns link period, in system cycles
  localparam int HALF = 4;

  // Both wires released at time zero, so the bus idles high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Bounded wait for SCL to rise; a slave may stretch it
  task automatic wait_high(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 200 && !ok; n++) begin
      @(negedge sys_clk);
      ok = (scl === 1'b1);
    end
  endtask

  // Start: SDA falls while SCL stays high, then SCL falls
  task automatic start_cond;
    sda_low = 1'b1;
    tick(HALF);
    scl_low = 1'b1;
    tick(HALF);
  endtask

  // One bit: data set while low, clock toggled by hand
  task automatic bit_cycle(input logic b, output logic s, output logic ok);
    sda_low = !b;
    tick(HALF);
    scl_low = 1'b0;
    wait_high(ok);
    tick(2);
    s = sda;
    tick(2);
    scl_low = 1'b1;
    tick(HALF);
  endtask

  // Stop: SDA rises while SCL is high; link clock then stands still
  task automatic stop_cond(output logic ok);
    sda_low = 1'b1;
    tick(HALF);
    scl_low = 1'b0;
    wait_high(ok);
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
endmodule

`default_nettype wire

// ==== usu_core.sv ====
/*
  Universal serial shift unit in its two-wire operating mode: open-drain
  SDA/SCL drive, shift data register, 4-bit edge counter, start-seen and
  overflow flags and the slave clock hold. Control bits are plain ports.
  Assumes software drives the control ports on sys_clk and that the
  bench resolves the open-drain wires from the output enables.
*/
`timescale 1ns/1ps
`default_nettype none

module usu_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sda_in,
  input wire logic scl_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic [1:0] wire_mode,
  input wire logic [1:0] clock_source_sel,
  input wire logic soft_clock_strobe,
  input wire logic timer_match,
  input wire logic sda_pin_output_latch,
  input wire logic scl_pin_output_latch,
  input wire logic sda_pin_direction,
  input wire logic scl_pin_direction,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic count_wr,
  input wire logic [3:0] count_wdata,
  input wire logic start_flag_clr,
  input wire logic ovf_flag_clr,
  input wire logic start_irq_en,
  input wire logic ovf_irq_en,
  output logic [7:0] shift_data_register,
  output logic [3:0] count,
  output logic start_seen_flag,
  output logic count_overflow_flag,
  output logic start_irq,
  output logic ovf_irq
);

  usu_det_if det_bus ();

  logic two_wire;
  logic ext_src;
  logic count_evt;
  logic shift_evt;
  logic wrap;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic out_bit_q;
  logic out_bit_d;
  logic start_flag_q;
  logic start_flag_d;
  logic ovf_flag_q;
  logic ovf_flag_d;
  usu_pkg::usu_hold_t hold_q;
  usu_pkg::usu_hold_t hold_d;
  logic sda_oe_n_q;
  logic sda_oe_n_d;
  logic scl_oe_n_q;
  logic scl_oe_n_d;
  logic start_irq_q;
  logic start_irq_d;
  logic ovf_irq_q;
  logic ovf_irq_d;

  // Raw pins go straight in; no filtering is applied on either line
  assign det_bus.sda_pin = sda_in;
  assign det_bus.scl_pin = scl_in;
  assign det_bus.enable = two_wire;

  usu_start_detect u_det (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus(det_bus)
  );

  // Mode decode and clock event selection
  always_comb begin
    two_wire = wire_mode[1];
    ext_src = clock_source_sel[1];
    // Edge-interrupt use is the external source with count preset to F
    case (clock_source_sel)
      usu_pkg::CS_SOFT_STROBE: begin
        shift_evt = soft_clock_strobe;
        count_evt = soft_clock_strobe;
      end
      usu_pkg::CS_TIMER_MATCH: begin
        shift_evt = timer_match;
        count_evt = timer_match;
      end
      usu_pkg::CS_EXT_RISE: begin
        shift_evt = det_bus.scl_rise;
        count_evt = det_bus.scl_rise | det_bus.scl_fall;
      end
      default: begin
        shift_evt = det_bus.scl_fall;
        count_evt = det_bus.scl_rise | det_bus.scl_fall;
      end
    endcase
    wrap = count_evt & (count_q == usu_pkg::COUNT_MAX) & ~count_wr;
  end

  // Shift register, edge counter and output bit latch
  always_comb begin
    shift_d = shift_q;
    count_d = count_q;
    out_bit_d = out_bit_q;
    if (data_wr) begin
      shift_d = data_wdata;
    end else if (shift_evt) begin
      shift_d = {shift_q[usu_pkg::DATA_MSB-1:0], det_bus.sda_s};
    end
    // Software load wins; 14 makes the acknowledge edges end in overflow
    if (count_wr) begin
      count_d = count_wdata;
    end else if (count_evt) begin
      count_d = count_q + usu_pkg::COUNT_ONE;
    end
    // With an external clock the output bit moves only on a data write or while SCL is low, away from the sampling edge
    if (data_wr || !ext_src || !det_bus.scl_s) begin
      out_bit_d = shift_d[usu_pkg::DATA_MSB];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_q <= usu_pkg::DATA_RST;
      count_q <= usu_pkg::COUNT_RST;
      out_bit_q <= 1'b1;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
      out_bit_q <= out_bit_d;
    end
  end

  // Sticky flags; a set in the clearing cycle wins over the clear
  always_comb begin
    start_flag_d = start_flag_q;
    ovf_flag_d = ovf_flag_q;
    if (start_flag_clr) begin
      start_flag_d = 1'b0;
    end
    if (det_bus.start_pulse) begin
      start_flag_d = 1'b1;
    end
    if (ovf_flag_clr) begin
      ovf_flag_d = 1'b0;
    end
    if (wrap) begin
      ovf_flag_d = 1'b1;
    end
    start_irq_d = start_flag_d & start_irq_en;
    ovf_irq_d = ovf_flag_d & ovf_irq_en;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
      start_irq_q <= 1'b0;
      ovf_irq_q <= 1'b0;
    end else begin
      start_flag_q <= start_flag_d;
      ovf_flag_q <= ovf_flag_d;
      start_irq_q <= start_irq_d;
      ovf_irq_q <= ovf_irq_d;
    end
  end

  // Clock hold: software gets time while SCL is pinned low
  always_comb begin
    hold_d = hold_q;
    if (!two_wire) begin
      hold_d = usu_pkg::USU_HOLD_NONE;
    end else begin
      case (hold_q)
        usu_pkg::USU_HOLD_NONE: begin
          if (det_bus.start_pulse) begin
            hold_d = usu_pkg::USU_HOLD_ARMED;
          end else if (wrap && wire_mode == usu_pkg::MODE_TWO_OVF_HOLD) begin
            hold_d = usu_pkg::USU_HOLD_OVF;
          end
        end
        usu_pkg::USU_HOLD_ARMED: begin
          if (start_flag_clr && !det_bus.start_pulse) begin
            hold_d = usu_pkg::USU_HOLD_NONE;
          end else if (det_bus.scl_fall) begin
            hold_d = usu_pkg::USU_HOLD_START;
          end
        end
        usu_pkg::USU_HOLD_START: begin
          if (start_flag_clr && !det_bus.start_pulse) begin
            hold_d = usu_pkg::USU_HOLD_NONE;
          end
        end
        usu_pkg::USU_HOLD_OVF: begin
          // Clearing overflow lets an unaddressed slave go idle
          if (det_bus.start_pulse) begin
            hold_d = usu_pkg::USU_HOLD_ARMED;
          end else if (ovf_flag_clr && !wrap) begin
            hold_d = usu_pkg::USU_HOLD_NONE;
          end
        end
        default: begin
          hold_d = usu_pkg::USU_HOLD_NONE;
        end
      endcase
    end
  end

  // Open-drain drive; enable low means the pin is pulled low
  always_comb begin
    sda_oe_n_d = 1'b1;
    scl_oe_n_d = 1'b1;
    if (wire_mode == usu_pkg::MODE_THREE) begin
      // SDA released; SCL follows the latch where the direction bit allows
      scl_oe_n_d = ~(scl_pin_direction & ~scl_pin_output_latch);
    end else if (two_wire) begin
      // Zero in top bit or latch pulls SDA: start, ack or data zero
      sda_oe_n_d = ~(sda_pin_direction & (~out_bit_q | ~sda_pin_output_latch));
      scl_oe_n_d = ~(scl_pin_direction & (~scl_pin_output_latch
        | hold_q == usu_pkg::USU_HOLD_START | hold_q == usu_pkg::USU_HOLD_OVF));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_q <= usu_pkg::USU_HOLD_NONE;
      sda_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
    end else begin
      hold_q <= hold_d;
      sda_oe_n_q <= sda_oe_n_d;
      scl_oe_n_q <= scl_oe_n_d;
    end
  end

  // Output data level is always low; only the enables move
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  assign sda_oe_n = sda_oe_n_q;
  assign scl_oe_n = scl_oe_n_q;
  assign shift_data_register = shift_q;
  assign count = count_q;
  assign start_seen_flag = start_flag_q;
  assign count_overflow_flag = ovf_flag_q;
  assign start_irq = start_irq_q;
  assign ovf_irq = ovf_irq_q;

  a_ovf_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (count_evt && !count_wr && count_q == usu_pkg::COUNT_MAX)
      |=> (ovf_flag_q && count_q == usu_pkg::COUNT_RST))
    else $error("overflow did not wrap and set flag");

  a_count_steps: assert property (@(posedge sys_clk) disable iff (rst)
    (count_evt && !count_wr) |=> (count_q == $past(count_q) + usu_pkg::COUNT_ONE))
    else $error("counter did not advance on clock edge");

  a_start_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    det_bus.start_pulse |=> start_seen_flag ##1 (start_irq == start_irq_en))
    else $error("start pulse did not set flag");

  a_start_hold_low: assert property (@(posedge sys_clk) disable iff (rst)
    (hold_q == usu_pkg::USU_HOLD_ARMED && det_bus.scl_fall && !start_flag_clr
      && two_wire && scl_pin_direction) |=> ##1 !scl_oe_n)
    else $error("scl not held after start");

  a_start_release: assert property (@(posedge sys_clk) disable iff (rst)
    (hold_q == usu_pkg::USU_HOLD_START && start_flag_clr && !det_bus.start_pulse)
      |=> hold_q == usu_pkg::USU_HOLD_NONE)
    else $error("start hold not released by clear");

  a_ovf_hold_low: assert property (@(posedge sys_clk) disable iff (rst)
    (wrap && wire_mode == usu_pkg::MODE_TWO_OVF_HOLD && hold_q == usu_pkg::USU_HOLD_NONE
      && !det_bus.start_pulse) |=> hold_q == usu_pkg::USU_HOLD_OVF)
    else $error("overflow did not hold scl");

  a_shift_sample: assert property (@(posedge sys_clk) disable iff (rst)
    (shift_evt && !data_wr) |=> (shift_q[0] == $past(det_bus.sda_s)
      && shift_q[7:1] == $past(shift_q[6:0])))
    else $error("sda not shifted in");

  a_sda_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (two_wire && sda_pin_direction && !sda_pin_output_latch) |=> !sda_oe_n)
    else $error("sda not pulled low by latch");

  a_mode_off_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (wire_mode == usu_pkg::MODE_OFF) |=> (sda_oe_n && scl_oe_n))
    else $error("pins driven with unit off");

endmodule

`default_nettype wire

// ==== usu_det_if.sv ====
/*
  Carrier between the shift unit core and its start condition detector.
  Assumes both ends run on sys_clk; raw pin levels enter unsynchronised.
*/
`timescale 1ns/1ps
`default_nettype none

interface usu_det_if;
  logic sda_pin;
  logic scl_pin;
  logic enable;
  logic sda_s;
  logic scl_s;
  logic scl_rise;
  logic scl_fall;
  logic start_pulse;

  modport det (
    input sda_pin,
    input scl_pin,
    input enable,
    output sda_s,
    output scl_s,
    output scl_rise,
    output scl_fall,
    output start_pulse
  );

  modport core (
    output sda_pin,
    output scl_pin,
    output enable,
    input sda_s,
    input scl_s,
    input scl_rise,
    input scl_fall,
    input start_pulse
  );
endinterface

`default_nettype wire

// ==== usu_pkg.sv ====
/*
  Shared constants for the two-wire serial shift unit: wire modes, clock
  source codes, counter limits, hold states and timing figures.
  Assumes a single 10 MHz system clock feeding every module of the unit.
*/
package usu_pkg;

  // Wire mode field values
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h1;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [1:0] MODE_TWO_OVF_HOLD = 2'h3;

  // Clock source select field values {high, low}
  localparam logic [1:0] CS_SOFT_STROBE = 2'h0;
  localparam logic [1:0] CS_TIMER_MATCH = 2'h1;
  localparam logic [1:0] CS_EXT_RISE = 2'h2;
  localparam logic [1:0] CS_EXT_FALL = 2'h3;

  // Counter and data register figures
  localparam int COUNT_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] COUNT_MAX = 4'hF;
  localparam logic [3:0] COUNT_ONE = 4'h1;
  localparam logic [3:0] COUNT_RST = 4'h0;
  localparam logic [3:0] COUNT_ACK_PRESET = 4'hE;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam int DATA_MSB = 7;

  // Clock-control hold states
  typedef enum logic [1:0] {
    USU_HOLD_NONE = 2'b00,
    USU_HOLD_ARMED = 2'b01,
    USU_HOLD_START = 2'b10,
    USU_HOLD_OVF = 2'b11
  } usu_hold_t;

  // Timing: least SDA delay in the start detector, rounded up to cycles
  localparam int SYS_CLK_PERIOD_NS = 100;
  localparam int SDA_DELAY_MIN_NS = 50;
  localparam int SDA_DELAY_MAX_NS = 300;
  localparam int SDA_DELAY_CYC_RAW =
    (SDA_DELAY_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int SDA_DELAY_CYC = (SDA_DELAY_CYC_RAW < 1) ? 1 : SDA_DELAY_CYC_RAW;

endpackage

// ==== usu_start_detect.sv ====
/*
  Pin synchronisers, SCL edge finder and start condition detector.
  Assumes pins are asynchronous to sys_clk and SCL stays at most at half
  the system clock rate, so every level lasts at least one sample.
*/
`timescale 1ns/1ps
`default_nettype none

module usu_start_detect (
  input wire logic sys_clk,
  input wire logic rst,
  usu_det_if.det bus
);

  logic [1:0] sda_sync_q;
  logic [1:0] sda_sync_d;
  logic [1:0] scl_sync_q;
  logic [1:0] scl_sync_d;
  logic scl_prev_q;
  logic scl_prev_d;
  logic [usu_pkg::SDA_DELAY_CYC:0] sda_dly_q;
  logic [usu_pkg::SDA_DELAY_CYC:0] sda_dly_d;

  // Two-stage synchronisers; stage 0 feeds only stage 1
  always_comb begin
    sda_sync_d = {sda_sync_q[0], bus.sda_pin};
    scl_sync_d = {scl_sync_q[0], bus.scl_pin};
    scl_prev_d = scl_sync_q[1];
    // SDA trails SCL so SCL is settled when SDA is seen falling
    sda_dly_d = {sda_dly_q[usu_pkg::SDA_DELAY_CYC-1:0], sda_sync_q[1]};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sda_sync_q <= 2'h3;
      scl_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_dly_q <= '1;
    end else begin
      sda_sync_q <= sda_sync_d;
      scl_sync_q <= scl_sync_d;
      scl_prev_q <= scl_prev_d;
      sda_dly_q <= sda_dly_d;
    end
  end

  // Edges of the bus clock, found by sampling; needs SCL under half rate
  assign bus.sda_s = sda_sync_q[1];
  assign bus.scl_s = scl_sync_q[1];
  assign bus.scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign bus.scl_fall = ~scl_sync_q[1] & scl_prev_q;

  // Start: delayed SDA falls while SCL high, two-wire modes only
  assign bus.start_pulse = bus.enable & scl_sync_q[1]
    & sda_dly_q[usu_pkg::SDA_DELAY_CYC] & ~sda_dly_q[usu_pkg::SDA_DELAY_CYC-1];

endmodule

`default_nettype wire
